//--- spi_master_model.sv
/* spi master standing in for the microcontroller, mode 0, 80 ns sclk.
   assumes the caller starts each frame on a falling clk_i edge. */
module spi_master_model (
   // pins toward the device
   output logic sclk_o,
   output logic chip_select_n_o,
   output logic si_o,
   // return line
   input wire logic so_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk_o = 1'b0;
      chip_select_n_o = 1'b1;
      si_o = 1'b0;
   end
   task automatic xfer(input logic [47:0] w, input int n,
      output logic [47:0] r);
      r = '0;
      chip_select_n_o = 1'b0;
      #80;
      for (int i = n - 1; i >= 0; i--) begin
         si_o = w[i];
         #40 sclk_o = 1'b1;
         r = {r[46:0], so_i};
         #40 sclk_o = 1'b0;
      end
      #40 chip_select_n_o = 1'b1;
      // released line must not look held
      si_o = ~si_o;
      #80;
   endtask
endmodule

//--- switch_config_defs.vh
/*
 * constants for the switch configuration register bank: word layout,
 * register addresses, field positions and reset values.
 * assumes inclusion by bare name from the design file.
 */
`ifndef SWITCH_CONFIG_DEFS_VH
`define SWITCH_CONFIG_DEFS_VH

`define WORD_W 16
`define CNT_W 5
`define WD_BIT 15
`define SEL_HI 14
`define SEL_LO 13
`define ADDR_HI 12
`define ADDR_LO 10
`define ZERO_BIT 9
`define DATA_HI 8

`define ADDR_STATUS 3'h0
`define ADDR_PWM 3'h1
`define ADDR_SWITCHING 3'h2
`define ADDR_FAULT 3'h3
`define ADDR_OVERCURRENT 3'h4
`define ADDR_GLOBAL 3'h5
`define ADDR_CALIB 3'h7

`define SOA_FAULT 5'h03
`define SOA_OVERCURRENT 5'h04
`define SOA_GLOBAL 5'h05
`define SOA_CALIB 5'h07

`define FAULT_RST 9'h040
`define OC_RST 9'h000
`define GLOBAL_RST 9'h000
`define CALIB_RST 9'h000

`define F_RETRY_UNLIM 6
`define F_RETRY_OFF 5
`define F_SHORT_OFF 4
`define F_ONOL_OFF 3
`define F_OFFOL_OFF 2
`define F_LED_TH 1
`define F_SENSE_HI 0

`define O_XENON_OFF 8
`define O_COOL_HI 7
`define O_COOL_LO 6
`define O_INRUSH_HI 5
`define O_INRUSH_LO 4
`define O_HI_SWAP 3
`define O_STEADY_HI 2
`define O_STEADY_LO 1
`define O_MODE 0

`define G_VDDFAIL_EN 8
`define G_PWM_EN 7
`define G_CLK_SEL 6
`define G_TEMP_EN 5
`define G_REPORT_ON 4
`define G_SENSE_HI 3
`define G_SENSE_LO 2
`define G_OV_OFF 0

`define SENSE_TRI 2'h0
`define SENSE_CURRENT 2'h1
`define SENSE_TEMP 2'h2
`define NORMAL_MODE 1'b1

`endif

//--- switch_config_spi_regs.v
/*
 * spi slave and configuration register bank of a four-output
 * high-side switch: fault management, overcurrent profile, global
 * and calibration registers plus the serial return word.
 * assumes sclk, cs and si come straight from pins (asynchronous,
 * sclk well below clk_i/4), so all three are synchronised here.
 * assumes the spi master works in mode 0 and keeps cs high for at
 * least four clk_i cycles between frames.
 * the status, pwm and switching registers live elsewhere; reading
 * them back through this block returns zero data.
 */
`include "switch_config_defs.vh"

module switch_config_spi_regs (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // spi pins
   input wire sclk_i,
   input wire chip_select_n_i,
   input wire si_i,
   output reg so_o,
   output reg so_oe_n_o,
   // per-output fault management, one bit per output
   output reg [3:0] retry_unlimited_o,
   output reg [3:0] retry_off_o,
   output reg [3:0] short_to_supply_off_o,
   output reg [3:0] on_openload_en_o,
   output reg [3:0] led_openload_threshold_o,
   output reg [3:0] off_openload_off_o,
   output reg [3:0] sense_high_ratio_o,
   // per-output overcurrent profile, packed by output
   output reg [3:0] xenon_profile_off_o,
   output reg [7:0] cooling_curve_o,
   output reg [7:0] inrush_curve_o,
   output reg [3:0] high_level_swap_o,
   output reg [7:0] steady_limit_o,
   output reg [3:0] overcurrent_mode_select_o,
   // global configuration
   output reg vddfail_failsafe_en_o,
   output reg pwm_module_en_o,
   output reg pwm_internal_clock_o,
   output reg direct_inputs_ignored_o,
   output reg [1:0] analog_sense_mode_o,
   output reg [1:0] sense_output_select_o,
   output reg overvoltage_protect_off_o,
   // calibration
   output reg [8:0] calib_data_o,
   output reg calib_start_o,
   // watchdog toggle bit of the last accepted frame
   output reg watchdog_toggle_bit_o
);

   // synchronisers: first stage read only by second
   reg [2:0] sync1_r;
   reg [2:0] sync2_r;
   reg sclk_d_r;
   reg cs_d_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 3'h1;
         sync2_r <= 3'h1;
         sclk_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         sync1_r <= {si_i, sclk_i, chip_select_n_i};
         sync2_r <= sync1_r;
         sclk_d_r <= sync2_r[1];
         cs_d_r <= sync2_r[0];
      end
   end

   // edge detect on the synchronised copies only
   wire cs_n = sync2_r[0];
   wire si_s = sync2_r[2];
   wire sclk_rise = sync2_r[1] & ~sclk_d_r;
   wire sclk_fall = ~sync2_r[1] & sclk_d_r;
   wire cs_fall = ~cs_n & cs_d_r;
   wire cs_rise = cs_n & ~cs_d_r;

   // register storage, one fault and overcurrent entry per output
   reg [8:0] fault_r [0:3];
   reg [8:0] ocp_r [0:3];
   reg [8:0] global_r;
   reg [8:0] calib_r;
   reg [4:0] soa_r;
   reg wd_r;
   reg [15:0] rx_r;
   reg [15:0] tx_r;
   reg [`CNT_W-1:0] bitcnt_r;
   reg started_r;
   reg in_frame_r;

   // fields of the last complete word
   wire wd_in = rx_r[`WD_BIT];
   wire [1:0] sel_in = rx_r[`SEL_HI:`SEL_LO];
   wire [2:0] addr_in = rx_r[`ADDR_HI:`ADDR_LO];
   wire [8:0] data_in = rx_r[`DATA_HI:0];
   wire zero_ok = ~rx_r[`ZERO_BIT];
   wire frame_ok = started_r && (bitcnt_r == {`CNT_W{1'b0}});


   // return word picked by stored status select
   // soa_r only moves on a valid status write, so the choice persists
   reg [8:0] ret_data;
   always @* begin
      case (soa_r[2:0])
         `ADDR_FAULT: begin
            ret_data = fault_r[soa_r[4:3]];
         end
         `ADDR_OVERCURRENT: begin
            ret_data = ocp_r[soa_r[4:3]];
         end
         `ADDR_GLOBAL: begin
            ret_data = (soa_r == `SOA_GLOBAL) ? global_r : 9'h000;
         end
         `ADDR_CALIB: begin
            ret_data = (soa_r == `SOA_CALIB) ? calib_r : 9'h000;
         end
         default: begin
            // status and pwm contents are not held in this block
            ret_data = 9'h000;
         end
      endcase
   end
   wire [15:0] ret_word = {wd_r, soa_r, `NORMAL_MODE, ret_data};


   // spi shifting
   // the echo path reuses rx_r, so no separate daisy-chain buffer
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_r <= 16'h0000;
         tx_r <= 16'h0000;
         bitcnt_r <= {`CNT_W{1'b0}};
         started_r <= 1'b0;
         in_frame_r <= 1'b0;
         so_o <= 1'b0;
         so_oe_n_o <= 1'b1;
      end else if (cs_fall) begin
         tx_r <= {ret_word[14:0], 1'b0};
         so_o <= ret_word[15];
         so_oe_n_o <= 1'b0;
         bitcnt_r <= {`CNT_W{1'b0}};
         started_r <= 1'b0;
         in_frame_r <= 1'b1;
      end else if (cs_rise) begin
         so_oe_n_o <= 1'b1;
         in_frame_r <= 1'b0;
      end else if (in_frame_r && !cs_n) begin
         if (sclk_rise) begin
            // mode 0: si taken on the rising sclk edge
            rx_r <= {rx_r[14:0], si_s};
            started_r <= 1'b1;
            if (bitcnt_r == 5'd15) begin
               bitcnt_r <= {`CNT_W{1'b0}};
            end else begin
               bitcnt_r <= bitcnt_r + 5'd1;
            end
         end
         if (sclk_fall) begin
            if (bitcnt_r == {`CNT_W{1'b0}}) begin
               // rx holds bits from 16 clocks ago
               so_o <= rx_r[15];
               tx_r <= {rx_r[14:0], 1'b0};
            end else begin
               // next return bit, msb first
               so_o <= tx_r[15];
               tx_r <= {tx_r[14:0], 1'b0};
            end
         end
      end
   end


   // register writes at a valid frame end
   // a refused frame leaves select and watchdog copy untouched too
   wire commit = cs_rise && in_frame_r && frame_ok && zero_ok;
   integer k;
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (k = 0; k < 4; k = k + 1) begin
            fault_r[k] <= `FAULT_RST;
            ocp_r[k] <= `OC_RST;
         end
         global_r <= `GLOBAL_RST;
         calib_r <= `CALIB_RST;
         soa_r <= 5'h00;
         wd_r <= 1'b0;
         calib_start_o <= 1'b0;
      end else begin
         calib_start_o <= 1'b0;
         if (commit) begin
            wd_r <= wd_in;
            case (addr_in)
               `ADDR_STATUS: begin
                  soa_r <= data_in[4:0];
               end
               `ADDR_FAULT: begin
                  fault_r[sel_in] <= data_in;
               end
               `ADDR_OVERCURRENT: begin
                  ocp_r[sel_in] <= data_in;
               end
               `ADDR_GLOBAL: begin
                  // global word needs select bits at zero
                  if (sel_in == 2'h0) begin
                     global_r <= data_in;
                  end
               end
               `ADDR_CALIB: begin
                  if (sel_in == 2'h0) begin
                     calib_r <= data_in;
                     calib_start_o <= 1'b1;
                  end
               end
               default: begin
                  // pwm and switching words belong elsewhere
                  soa_r <= soa_r;
               end
            endcase
         end
      end
   end


   // decoded configuration outputs, one generate entry per output
   // one extra stage keeps every output straight from a flop
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : per_out
         always @(posedge clk_i) begin
            if (rst_i) begin
               // fault reset value has the unlimited bit set
               retry_unlimited_o[g] <= 1'b1;
               retry_off_o[g] <= 1'b0;
               short_to_supply_off_o[g] <= 1'b0;
               on_openload_en_o[g] <= 1'b1;
               led_openload_threshold_o[g] <= 1'b0;
               off_openload_off_o[g] <= 1'b0;
               sense_high_ratio_o[g] <= 1'b0;
               xenon_profile_off_o[g] <= 1'b0;
               cooling_curve_o[2*g+1:2*g] <= 2'h0;
               inrush_curve_o[2*g+1:2*g] <= 2'h0;
               high_level_swap_o[g] <= 1'b0;
               steady_limit_o[2*g+1:2*g] <= 2'h0;
               overcurrent_mode_select_o[g] <= 1'b0;
            end else begin
               retry_unlimited_o[g] <= fault_r[g][`F_RETRY_UNLIM];
               retry_off_o[g] <= fault_r[g][`F_RETRY_OFF];
               short_to_supply_off_o[g] <= fault_r[g][`F_SHORT_OFF];
               on_openload_en_o[g] <= ~fault_r[g][`F_ONOL_OFF];
               led_openload_threshold_o[g] <=
                  ~fault_r[g][`F_ONOL_OFF] & fault_r[g][`F_LED_TH];
               off_openload_off_o[g] <= fault_r[g][`F_OFFOL_OFF];
               sense_high_ratio_o[g] <= fault_r[g][`F_SENSE_HI];
               xenon_profile_off_o[g] <= ocp_r[g][`O_XENON_OFF];
               cooling_curve_o[2*g+1:2*g] <=
                  ocp_r[g][`O_COOL_HI:`O_COOL_LO];
               inrush_curve_o[2*g+1:2*g] <=
                  ocp_r[g][`O_INRUSH_HI:`O_INRUSH_LO];
               high_level_swap_o[g] <= ocp_r[g][`O_HI_SWAP];
               steady_limit_o[2*g+1:2*g] <=
                  ocp_r[g][`O_STEADY_HI:`O_STEADY_LO];
               overcurrent_mode_select_o[g] <= ocp_r[g][`O_MODE];
            end
         end
      end
   endgenerate

   always @(posedge clk_i) begin
      if (rst_i) begin
         vddfail_failsafe_en_o <= 1'b0;
         pwm_module_en_o <= 1'b0;
         pwm_internal_clock_o <= 1'b0;
         direct_inputs_ignored_o <= 1'b0;
         analog_sense_mode_o <= `SENSE_TRI;
         sense_output_select_o <= 2'h0;
         overvoltage_protect_off_o <= 1'b0;
         calib_data_o <= `CALIB_RST;
         watchdog_toggle_bit_o <= 1'b0;
      end else begin
         vddfail_failsafe_en_o <= global_r[`G_VDDFAIL_EN];
         pwm_module_en_o <= global_r[`G_PWM_EN];
         direct_inputs_ignored_o <= global_r[`G_PWM_EN];
         // clock select only counts with pwm on
         pwm_internal_clock_o <= global_r[`G_PWM_EN] &
            global_r[`G_CLK_SEL];
         if (global_r[`G_REPORT_ON]) begin
            analog_sense_mode_o <= `SENSE_CURRENT;
         end else if (global_r[`G_TEMP_EN]) begin
            analog_sense_mode_o <= `SENSE_TEMP;
         end else begin
            // pin left floating by default
            analog_sense_mode_o <= `SENSE_TRI;
         end
         sense_output_select_o <= global_r[`G_SENSE_HI:`G_SENSE_LO];
         overvoltage_protect_off_o <= global_r[`G_OV_OFF];
         calib_data_o <= calib_r;
         watchdog_toggle_bit_o <= wd_r;
      end
   end

endmodule

//--- switch_config_spi_regs_monitor.sv
/* checker for the switch configuration register bank, port level.
   assumes a bind onto the top module and a single clock domain. */
module switch_config_spi_regs_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // watched ports
   input wire logic chip_select_n_i,
   input wire logic so_oe_n_o,
   input wire logic [3:0] retry_off_o,
   input wire logic [3:0] on_openload_en_o,
   input wire logic [3:0] led_openload_threshold_o,
   input wire logic pwm_module_en_o,
   input wire logic direct_inputs_ignored_o,
   input wire logic [1:0] analog_sense_mode_o,
   input wire logic calib_start_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_idle; chip_select_n_i [*8]; endsequence
   sequence s_busy; !chip_select_n_i [*6]; endsequence
   property p_idle_float; s_idle |-> so_oe_n_o; endproperty
   a_idle_float: assert property (p_idle_float)
      else $error("so driven outside a frame");
   property p_drive; $fell(chip_select_n_i) |-> ##[1:6] !so_oe_n_o;
   endproperty
   a_drive: assert property (p_drive)
      else $error("so not driven after select");
   property p_busy; s_busy |-> !so_oe_n_o; endproperty
   a_busy: assert property (p_busy)
      else $error("so released inside a frame");
   // config may only move once the frame has closed
   property p_cfg; $changed(retry_off_o) |-> chip_select_n_i; endproperty
   a_cfg: assert property (p_cfg)
      else $error("config changed inside a frame");
   property p_pulse; calib_start_o |=> !calib_start_o; endproperty
   a_pulse: assert property (p_pulse)
      else $error("calibration start longer than one cycle");
   property p_led; (led_openload_threshold_o & ~on_openload_en_o) == 4'h0;
   endproperty
   a_led: assert property (p_led)
      else $error("led threshold with detection off");
   property p_ign; direct_inputs_ignored_o == pwm_module_en_o; endproperty
   a_ign: assert property (p_ign)
      else $error("direct inputs not tied to pwm enable");
   property p_mode; analog_sense_mode_o != 2'h3; endproperty
   a_mode: assert property (p_mode)
      else $error("illegal sense mode");
endmodule
bind switch_config_spi_regs switch_config_spi_regs_monitor i_mon (.*);

//--- switch_config_spi_regs_tb.sv
/* self-checking bench: register writes read back via the return word,
   then echo, refused frames and reset. assumes spi_master_model. */
module switch_config_spi_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wire sclk_i, chip_select_n_i, si_i, so_o, so_oe_n_o, calib_start_o;
   wire vddfail_failsafe_en_o, pwm_module_en_o, pwm_internal_clock_o;
   wire direct_inputs_ignored_o, overvoltage_protect_off_o;
   wire watchdog_toggle_bit_o;
   wire [3:0] retry_unlimited_o, retry_off_o, short_to_supply_off_o;
   wire [3:0] on_openload_en_o, led_openload_threshold_o;
   wire [3:0] off_openload_off_o, sense_high_ratio_o, xenon_profile_off_o;
   wire [3:0] high_level_swap_o, overcurrent_mode_select_o;
   wire [7:0] cooling_curve_o, inrush_curve_o, steady_limit_o;
   wire [1:0] analog_sense_mode_o, sense_output_select_o;
   wire [8:0] calib_data_o;
   int mismatches = 0;
   int total_checks = 0;
   int starts = 0;
   logic [47:0] r;
   logic [29:0] rows [8] = '{{16'h4c7f, 5'h13, 9'h07f},
      {16'h2c15, 5'h03, 9'h040}, {16'h71ff, 5'h1c, 9'h1ff},
      {16'h50a5, 5'h14, 9'h0a5}, {16'h15fd, 5'h05, 9'h1fd},
      {16'h1d5b, 5'h07, 9'h15b}, {16'h3400, 5'h05, 9'h1fd},
      {16'h4e00, 5'h13, 9'h07f}};
   switch_config_spi_regs i_dut (.*);
   spi_master_model i_master (.sclk_o(sclk_i),
      .chip_select_n_o(chip_select_n_i), .si_o(si_i), .so_i(so_o));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (calib_start_o === 1'b1)
         starts++;
   end
   task automatic chk(input string nm, input logic [47:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic f16(input logic [15:0] w);
      i_master.xfer({32'h0, w}, 16, r);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic reset_pulse;
      rst_i = 1'b1;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk("rst", {retry_unlimited_o, on_openload_en_o, retry_off_o,
         so_oe_n_o, calib_data_o}, {4'hf, 4'hf, 4'h0, 1'b1, 9'h0});
   endtask
   initial begin
      #300000;
      mismatches++;
      summarize;
   end
   initial begin
      reset_pulse;
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         f16(rows[i][29:14]);
         f16({11'h400, rows[i][13:9]});
         f16({11'h400, rows[i][13:9]});
         chk("ret", r[15:0], {1'b1, rows[i][13:9], 1'b1, rows[i][8:0]});
      end
      chk("fault", {retry_unlimited_o, retry_off_o,
         short_to_supply_off_o, on_openload_en_o, led_openload_threshold_o,
         off_openload_off_o, sense_high_ratio_o}, 28'hd46b066);
      chk("ocp", {xenon_profile_off_o, cooling_curve_o,
         inrush_curve_o, high_level_swap_o, steady_limit_o,
         overcurrent_mode_select_o}, 36'h8e0e08e0c);
      chk("glob", {vddfail_failsafe_en_o, pwm_module_en_o,
         pwm_internal_clock_o, direct_inputs_ignored_o, analog_sense_mode_o,
         sense_output_select_o, overvoltage_protect_off_o}, 9'h1ef);
      chk("start", starts, 1);
      chk("cal", {calib_data_o, watchdog_toggle_bit_o}, 10'h2b7);
      $display("test rows done");
      i_master.xfer({16'h0, 16'h5aa5, 16'h8007}, 32, r);
      chk("echo", r[15:0], 16'h5aa5);
      f16(16'h15fd);
      f16(16'h15fd);
      chk("persist", r[15:0], 16'h1f5b);
      $display("test echo done");
      for (int n = 15; n <= 17; n += 2) begin
         i_master.xfer(48'h1c00, n, r);
      end
      f16(16'h8007);
      f16(16'h8007);
      chk("short", {calib_data_o, r[8:0]}, {9'h15b, 9'h15b});
      $display("test length done");
      reset_pulse;
      $display("test rerun reset done");
      summarize;
   end
endmodule
